/* File: design/tcs_pkg.sv */
// Shared constants for the thermocouple SPI register port and its controller
package tcs_pkg;

  // Register file geometry
  localparam int TCS_NREG = 16;
  localparam int TCS_NUM_RW = 12;
  localparam logic [6:0] TCS_NREG_PTR = 7'h10;
  localparam logic [7:0] TCS_UNMAPPED = 8'hFF;

  // Register indices (read address 0x0n, write address 0x8n)
  localparam logic [3:0] TCS_IDX_CONFIG_MAIN = 4'h0;
  localparam logic [3:0] TCS_IDX_COLD_TEMP_MSB = 4'hA;
  localparam logic [3:0] TCS_IDX_COLD_TEMP_LSB = 4'hB;
  localparam logic [3:0] TCS_IDX_HOT_TEMP_BYTE2 = 4'hC;
  localparam logic [3:0] TCS_IDX_HOT_TEMP_BYTE1 = 4'hD;
  localparam logic [3:0] TCS_IDX_HOT_TEMP_BYTE0 = 4'hE;
  localparam logic [3:0] TCS_IDX_FAULT_FLAGS = 4'hF;
  localparam logic [6:0] TCS_FIRST_RO_PTR = 7'h0C;

  // Reset image, index 15 first down to index 0
  localparam logic [15:0][7:0] TCS_REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h80, 8'hFF, 8'h7F, 8'hC0, 8'h7F, 8'hFF, 8'h03, 8'h00};

  // config_main field positions
  localparam int TCS_CONTINUOUS_CONVERSION = 7;
  localparam int TCS_SINGLE_CONVERSION_REQUEST = 6;
  localparam int TCS_OPEN_WIRE_TEST_HI = 5;
  localparam int TCS_OPEN_WIRE_TEST_LO = 4;
  localparam int TCS_REF_SENSOR_DISABLE = 3;
  localparam int TCS_FAULT_MODE = 2;
  localparam int TCS_ALARM_FLAGS_CLEAR = 1;
  localparam int TCS_LINE_NOTCH_SELECT = 0;

  // Link framing
  localparam logic [2:0] TCS_LAST_BIT = 3'h7;
  localparam int TCS_DIRECTION_BIT = 7;

  // Controller register map (byte addresses on the AHB-Lite bus)
  localparam logic [7:0] TCS_AHB_CMD = 8'h00;
  localparam logic [7:0] TCS_AHB_STATUS = 8'h04;
  localparam logic [3:0] TCS_AHB_DATA_PAGE = 4'h1;
  localparam int TCS_CMD_LEN_LSB = 8;
  localparam int TCS_CMD_CPOL_BIT = 16;
  localparam int TCS_STAT_BUSY_BIT = 0;
  localparam int TCS_STAT_READY_BIT = 1;

  // Link clock made by the controller
  localparam int TCS_REF_NS = 4;
  localparam int TCS_SCLK_HALF_NS = 64;
  localparam int TCS_SCLK_HALF =
    (TCS_SCLK_HALF_NS + TCS_REF_NS - 1) / TCS_REF_NS;

endpackage

/* File: design/tcs_link_if.sv */
// Four-wire link plus data-ready line between controller and register port
`timescale 1ns/10ps
interface tcs_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo_out;
  logic sdo_oe_n;
  logic sdo;
  logic data_ready_n;

  // Released line reads high, as with a pull-up
  assign sdo = sdo_oe_n ? 1'b1 : sdo_out;

  modport dev (
    input cs_n,
    input sclk,
    input sdi,
    output sdo_out,
    output sdo_oe_n,
    output data_ready_n
  );

  modport host (
    output cs_n,
    output sclk,
    output sdi,
    input sdo,
    input data_ready_n
  );
endinterface

/* File: design/tcs_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module tcs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
  } tcs_sync_state_t;

  tcs_sync_state_t st;
  tcs_sync_state_t nx;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("tcs_sync WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second stage
  always_comb begin
    nx.meta = din;
    nx.stage2 = st.meta;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= {INIT, INIT};
    end else begin
      st <= nx;
    end
  end

  assign dout = st.stage2;
endmodule // tcs_sync

/* File: design/tcs_dev.sv */
// Register port end: SPI slave with sixteen 8-bit registers
`timescale 1ns/10ps
// Operation
// - Each chip-select low period is one transaction
// - Idle clock level sampled when chip select falls
// - One clock per bit, bytes MSB first
// - Address byte first, then data bytes
// - Address MSB: 0 read, 1 write
// - Pointer increments per byte, wraps within half
// - Unmapped read address returns FFh
// - Writes to read-only registers are ignored
// - Data-ready low on new hot result
// - Hot read completion, or cold read with sensor on, returns data-ready high
// - Output released until read data is ready
// - Capture and shift edges follow idle level
// - Master uses clock phase one
// - Clock toggles only during framed bits
// - Single-byte access: address, one byte, deselect
// - Sixteen 8-bit registers selected by address
// - Read at 0x0n, write at 0x8n
// - config_main bit layout fixed, bit 7 down
// - One-shot starts when chip select rises
// - Alarm clear bit returns to zero itself
module tcs_dev
  import tcs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  tcs_link_if.dev LINK,
  input wire logic RESULT_VALID,
  input wire logic [23:0] RESULT_DATA,
  input wire logic COLD_VALID,
  input wire logic [15:0] COLD_DATA,
  input wire logic [7:0] FAULT_STATUS,
  output logic [TCS_NUM_RW*8-1:0] CTRL_REGS,
  output logic CONVERT_START,
  output logic FAULT_CLEAR
);

  typedef struct packed {
    logic cs_q;
    logic sclk_q;
    logic cpol;
    logic [2:0] bits;
    logic [7:0] sin;
    logic addr_ok;
    logic wr;
    logic [6:0] ptr;
    logic [7:0] sout;
    logic sdo;
    logic oe_n;
    logic [15:0][7:0] regs;
    logic rd_hot;
    logic rd_cold;
    logic ready_n;
    logic start;
    logic clr;
  } tcs_dev_state_t;

  tcs_dev_state_t st;
  tcs_dev_state_t nx;
  logic [2:0] pins;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic rise;
  logic fall;
  logic cap_edge;
  logic shift_edge;
  logic [7:0] in_byte;

  // Pins come from the master's domain; resync before use
  tcs_sync #(
    .WIDTH(3),
    .INIT(3'h4)
  ) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din({LINK.cs_n, LINK.sclk, LINK.sdi}),
    .dout(pins)
  );

  assign cs_s = pins[2];
  assign sclk_s = pins[1];
  assign sdi_s = pins[0];

  // Edge finding on the resynced clock
  assign rise = sclk_s & ~st.sclk_q;
  assign fall = ~sclk_s & st.sclk_q;
  assign cap_edge = st.cpol ? rise : fall;
  assign shift_edge = st.cpol ? fall : rise;
  assign in_byte = {st.sin[6:0], sdi_s};

  // Read mux; holes in the map answer all ones
  function automatic logic [7:0] rd_val(
    input logic [15:0][7:0] r,
    input logic [6:0] a
  );
    logic [7:0] v;
    v = TCS_UNMAPPED;
    if (a < TCS_NREG_PTR) begin
      v = r[a[3:0]];
    end
    return v;
  endfunction

  // Next-state logic for the whole port
  always_comb begin
    nx = st;
    nx.cs_q = cs_s;
    nx.sclk_q = sclk_s;
    nx.start = 1'b0;
    // Clear request lives one cycle, then the bit drops
    nx.clr = st.regs[TCS_IDX_CONFIG_MAIN][TCS_ALARM_FLAGS_CLEAR];
    nx.regs[TCS_IDX_CONFIG_MAIN][TCS_ALARM_FLAGS_CLEAR] = 1'b0;
    nx.regs[TCS_IDX_FAULT_FLAGS] = FAULT_STATUS;
    if (RESULT_VALID) begin
      {nx.regs[TCS_IDX_HOT_TEMP_BYTE2], nx.regs[TCS_IDX_HOT_TEMP_BYTE1],
       nx.regs[TCS_IDX_HOT_TEMP_BYTE0]} = RESULT_DATA;
    end
    // External cold value stays put while the sensor is off
    if (COLD_VALID &&
        !st.regs[TCS_IDX_CONFIG_MAIN][TCS_REF_SENSOR_DISABLE]) begin
      {nx.regs[TCS_IDX_COLD_TEMP_MSB],
       nx.regs[TCS_IDX_COLD_TEMP_LSB]} = COLD_DATA;
    end
    if (cs_s) begin
      // Deselected: nothing on the pins matters
      nx.bits = '0;
      nx.addr_ok = 1'b0;
      nx.oe_n = 1'b1;
      nx.sdo = 1'b0;
      if (!st.cs_q) begin
        // End of frame; a partial byte is simply dropped
        if (st.regs[TCS_IDX_CONFIG_MAIN][TCS_SINGLE_CONVERSION_REQUEST]) begin
          nx.start = 1'b1;
          nx.regs[TCS_IDX_CONFIG_MAIN][TCS_SINGLE_CONVERSION_REQUEST] =
            1'b0;
        end
        if (st.rd_hot || (st.rd_cold &&
            !st.regs[TCS_IDX_CONFIG_MAIN][TCS_REF_SENSOR_DISABLE])) begin
          nx.ready_n = 1'b1;
        end
        nx.rd_hot = 1'b0;
        nx.rd_cold = 1'b0;
      end
    end else if (st.cs_q) begin
      // Frame opens; clock level now is the idle level
      nx.cpol = sclk_s;
      nx.bits = '0;
    end else if (cap_edge) begin
      nx.sin = in_byte;
      nx.bits = st.bits + 3'h1;
      if (st.bits == TCS_LAST_BIT) begin
        if (!st.addr_ok) begin
          // First byte of every frame is the address
          nx.addr_ok = 1'b1;
          nx.wr = in_byte[TCS_DIRECTION_BIT];
          nx.ptr = in_byte[6:0];
          nx.sout = rd_val(st.regs, in_byte[6:0]);
        end else begin
          // Only whole bytes reach the registers
          if (st.wr && st.ptr < TCS_FIRST_RO_PTR) begin
            nx.regs[st.ptr[3:0]] = in_byte;
          end
          if (!st.wr) begin
            if (st.ptr >= TCS_FIRST_RO_PTR &&
                st.ptr[3:0] <= TCS_IDX_HOT_TEMP_BYTE0 &&
                st.ptr < TCS_NREG_PTR) begin
              nx.rd_hot = 1'b1;
            end
            if (st.ptr[6:1] == {3'h0, TCS_IDX_COLD_TEMP_MSB[3:1]} &&
                st.ptr < TCS_NREG_PTR) begin
              nx.rd_cold = 1'b1;
            end
          end
          // Seven-bit pointer keeps the direction bit fixed
          nx.ptr = st.ptr + 7'h01;
          nx.sout = rd_val(st.regs, st.ptr + 7'h01);
        end
      end
    end else if (shift_edge && st.addr_ok && !st.wr) begin
      // Output is driven only once a data byte is loaded
      nx.oe_n = 1'b0;
      nx.sdo = st.sout[7];
      nx.sout = {st.sout[6:0], 1'b0};
    end
    // A new result beats a read that ends in the same cycle
    if (RESULT_VALID) begin
      nx.ready_n = 1'b0;
    end
  end

  // State register
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      st <= '0;
      st.cs_q <= 1'b1;
      st.oe_n <= 1'b1;
      st.ready_n <= 1'b1;
      st.regs <= TCS_REG_RESET;
    end else begin
      st <= nx;
    end
  end

  // All outputs straight from state
  assign LINK.sdo_out = st.sdo;
  assign LINK.sdo_oe_n = st.oe_n;
  assign LINK.data_ready_n = st.ready_n;
  assign CTRL_REGS = st.regs[TCS_NUM_RW-1:0];
  assign CONVERT_START = st.start;
  assign FAULT_CLEAR = st.clr;

endmodule // tcs_dev

/* File: design/tcs_host.sv */
// Controller end: AHB-Lite slave registers driving the SPI master
`timescale 1ns/10ps
module tcs_host
  import tcs_pkg::*;
#(
  parameter int HALF_CYCLES = TCS_SCLK_HALF
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  tcs_link_if.host LINK
);

  typedef enum logic [2:0] {
    H_IDLE, H_PRE, H_TRAIL, H_LEAD, H_END
  } tcs_hst_t;

  typedef struct packed {
    logic dp;
    logic dpw;
    logic [7:0] dpa;
    logic hrdy;
    logic [31:0] rdata;
    tcs_hst_t fsm;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic cpol;
    logic [7:0] tmr;
    logic [7:0] addr;
    logic [3:0] len;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bitn;
    logic [4:0] bidx;
    logic [15:0][7:0] dbuf;
  } tcs_host_state_t;

  localparam logic [7:0] HALF = 8'(HALF_CYCLES);

  tcs_host_state_t st;
  tcs_host_state_t nx;
  logic [1:0] pins;
  logic sdo_s;
  logic ready_s;
  logic [7:0] rx_byte;

  // Long enough for both resync delays inside half a clock
  generate
    if (HALF_CYCLES < 8 || HALF_CYCLES > 255) begin : g_bad_half
      $error("tcs_host HALF_CYCLES must be 8 to 255");
    end
  endgenerate

  tcs_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din({LINK.sdo, LINK.data_ready_n}),
    .dout(pins)
  );

  assign sdo_s = pins[1];
  assign ready_s = pins[0];
  assign rx_byte = {st.rx[6:0], sdo_s};

  always_comb begin
    nx = st;
    nx.hrdy = 1'b1;
    // Bus side: one wait state, then the answer
    if (st.dp) begin
      nx.dp = 1'b0;
      nx.rdata = '0;
      if (st.dpa[7:4] == TCS_AHB_DATA_PAGE) begin
        for (int i = 0; i < 4; i++) begin
          if (st.dpw) begin
            nx.dbuf[{st.dpa[3:2], 2'(i)}] = HWDATA[i*8 +: 8];
          end
          nx.rdata[i*8 +: 8] = st.dbuf[{st.dpa[3:2], 2'(i)}];
        end
      end else if (st.dpa == TCS_AHB_CMD) begin
        nx.rdata[7:0] = st.addr;
        nx.rdata[TCS_CMD_LEN_LSB +: 4] = st.len;
        nx.rdata[TCS_CMD_CPOL_BIT] = st.cpol;
        // Command while busy is dropped
        if (st.dpw && st.fsm == H_IDLE) begin
          nx.addr = HWDATA[7:0];
          nx.len = HWDATA[TCS_CMD_LEN_LSB +: 4];
          nx.cpol = HWDATA[TCS_CMD_CPOL_BIT];
          nx.sclk = HWDATA[TCS_CMD_CPOL_BIT];
          nx.fsm = H_PRE;
          nx.tmr = HALF;
        end
      end else if (st.dpa == TCS_AHB_STATUS) begin
        nx.rdata[TCS_STAT_BUSY_BIT] = (st.fsm != H_IDLE);
        nx.rdata[TCS_STAT_READY_BIT] = ~ready_s;
      end
    end else if (HSEL && HTRANS[1] && HREADY) begin
      nx.dp = 1'b1;
      nx.dpw = HWRITE;
      nx.dpa = {HADDR[7:2], 2'h0};
      nx.hrdy = 1'b0;
    end
    // Link side: timer paces every clock edge
    if (st.tmr != 8'h00) begin
      nx.tmr = st.tmr - 8'h01;
    end else begin
      case (st.fsm)
        H_IDLE: begin
          // Listed so the default cannot undo a start from the bus
        end
        H_PRE: begin
          // Idle level settled before the frame opens
          nx.cs_n = 1'b0;
          nx.tx = st.addr;
          nx.bitn = '0;
          nx.bidx = '0;
          nx.fsm = H_TRAIL;
          nx.tmr = HALF;
        end
        H_TRAIL: begin
          // Leading edge: drive next bit
          nx.sclk = ~st.cpol;
          nx.sdi = st.tx[7];
          nx.tx = {st.tx[6:0], 1'b0};
          nx.fsm = H_LEAD;
          nx.tmr = HALF;
        end
        H_LEAD: begin
          // Trailing edge: sample the slave
          nx.sclk = st.cpol;
          nx.rx = rx_byte;
          nx.bitn = st.bitn + 3'h1;
          nx.fsm = H_TRAIL;
          nx.tmr = HALF;
          if (st.bitn == TCS_LAST_BIT) begin
            if (st.bidx != 5'h00 && !st.addr[TCS_DIRECTION_BIT]) begin
              nx.dbuf[4'(st.bidx - 5'h01)] = rx_byte;
            end
            if (st.bidx == {1'b0, st.len} + 5'h01) begin
              nx.fsm = H_END;
            end else begin
              nx.bidx = st.bidx + 5'h01;
              nx.tx = st.addr[TCS_DIRECTION_BIT] ? st.dbuf[st.bidx[3:0]]
                                                 : 8'h00;
            end
          end
        end
        H_END: begin
          nx.cs_n = 1'b1;
          nx.sdi = 1'b0;
          nx.fsm = H_IDLE;
        end
        default: begin
          nx.fsm = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      st <= '0;
      st.hrdy <= 1'b1;
      st.cs_n <= 1'b1;
      st.fsm <= H_IDLE;
    end else begin
      st <= nx;
    end
  end

  assign HRDATA = st.rdata;
  assign HREADYOUT = st.hrdy;
  assign HRESP = 1'b0;
  assign LINK.cs_n = st.cs_n;
  assign LINK.sclk = st.sclk;
  assign LINK.sdi = st.sdi;

endmodule // tcs_host

/* File: verif/tcs_link_monitor.sv */
// Checker on the link between controller and register port
`timescale 1ns/10ps
module tcs_link_monitor (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic sdo,
  input wire logic data_ready_n
);
  logic sclk_q, cpol, wr, adone;
  logic [2:0] bits;
  logic [4:0] nbyte;
  logic [7:0] sh;
  logic [3:0] hi_cnt;
  wire edge_s = !cs_n && (sclk != sclk_q);
  wire cap = edge_s && (sclk == cpol);
  wire shf = edge_s && (sclk != cpol);
  wire rd_ph = !cs_n && adone && !wr;

  // Frame tracker; idle level follows sclk until chip select falls
  always_ff @(posedge REF_CLK) begin
    sclk_q <= sclk;
    if (!RSTN || cs_n) begin
      bits <= 3'h0;
      nbyte <= 5'h00;
      adone <= 1'b0;
      cpol <= sclk;
    end else if (cap) begin
      sh <= {sh[6:0], sdi};
      bits <= bits + 3'h1;
      if (bits == 3'h7) begin
        adone <= 1'b1;
        if (!adone) wr <= sh[6];  // First bit of the address byte
        if (nbyte != 5'h1F) nbyte <= nbyte + 5'h01;
      end
    end
    hi_cnt <= (!RSTN || !cs_n) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // Read data shift, then the output must be driven shortly after
  sequence s_read_shift;
    rd_ph && shf;
  endsequence
  sequence s_drive;
    ##[1:6] !sdo_oe_n;
  endsequence

  chk_idle_level: assert property (
    $fell(cs_n) |-> $stable(sclk) [*4])
    else $error("sclk moved as chip select fell");
  chk_whole_bytes: assert property (
    $rose(cs_n) |-> bits == 3'h0)
    else $error("frame ended inside a byte");
  chk_data_follows: assert property (
    $rose(cs_n) |-> nbyte >= 5'h02)
    else $error("frame without data byte");
  chk_addr_hiz: assert property (
    !cs_n && !adone |-> sdo_oe_n)
    else $error("output driven during address byte");
  chk_write_hiz: assert property (
    !cs_n && adone && wr |-> sdo_oe_n)
    else $error("output driven during write");
  chk_read_drive: assert property (
    s_read_shift |-> s_drive)
    else $error("read data not driven after shift edge");
  chk_read_stable: assert property (
    rd_ph && cap |-> !sdo_oe_n && $stable(sdo))
    else $error("read bit moving at capture edge");
  chk_end_idle: assert property (
    $rose(cs_n) |-> sclk == cpol)
    else $error("clock not idle at frame end");
  chk_ready_release: assert property (
    $rose(data_ready_n) |-> cs_n && hi_cnt <= 4'h8)
    else $error("data ready released outside frame end");
  chk_desel_release: assert property (
    cs_n [*8] |-> sdo_oe_n)
    else $error("output driven while deselected");
endmodule // tcs_link_monitor

/* File: verif/thermocouple_spi_register_port_tb.sv */
// Bench joining controller and register port over the link
`timescale 1ns/10ps
module thermocouple_spi_register_port_tb
  import tcs_pkg::*;
();
  typedef struct {logic [31:0] v; logic [31:0] m;} tcs_note_t;
  logic REF_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA, junk;
  logic HREADYOUT, HRESP, CONVERT_START, FAULT_CLEAR;
  logic RESULT_VALID = 1'b0;
  logic COLD_VALID = 1'b0;
  logic [23:0] RESULT_DATA = 24'h0;
  logic [15:0] COLD_DATA = 16'h0;
  logic [7:0] FAULT_STATUS = 8'h0;
  logic [TCS_NUM_RW*8-1:0] CTRL_REGS;
  logic [7:0] seed = 8'h23;
  logic [7:0] mdl [16];
  logic [7:0] wb [16];
  logic [7:0] wm [16];
  logic rd_dp = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int n_conv = 0;
  int n_clr = 0;
  tcs_note_t notes [$];
  tcs_note_t nt;

  tcs_link_if link ();
  tcs_host u_tcs_host (.REF_CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .LINK(link.host));
  tcs_dev u_tcs_dev (.REF_CLK, .RSTN, .LINK(link.dev), .RESULT_VALID,
    .RESULT_DATA, .COLD_VALID, .COLD_DATA, .FAULT_STATUS, .CTRL_REGS,
    .CONVERT_START, .FAULT_CLEAR);
  tcs_link_monitor u_tcs_link_monitor (.REF_CLK, .RSTN, .cs_n(link.cs_n),
    .sclk(link.sclk), .sdi(link.sdi), .sdo_out(link.sdo_out),
    .sdo_oe_n(link.sdo_oe_n), .sdo(link.sdo),
    .data_ready_n(link.data_ready_n));

  always #2 REF_CLK = ~REF_CLK;

  // Eight-bit maximal-length sequence
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One single AHB-Lite transfer; waits on the slave, no fixed latency
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
    r = HRDATA;
  endtask

  // Read with a note; a zero mask marks a poll with nothing to compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, output logic [31:0] r);
    notes.push_back('{e, m});
    ahb(1'b0, a, 32'h0, r);
  endtask

  // One link frame of n data bytes through the controller
  task automatic xfer(input logic [7:0] a, input int n, input logic cp);
    logic [6:0] p;
    logic [31:0] r, e, m;
    int i, j;
    p = a[6:0];
    for (i = 0; i < n; i++) begin
      wb[i] = rnd();
      if (p == 7'h00) wb[i] = (wb[i] & 8'h35) | 8'h42;  // Keep sensor on
      if (a[7] && p < 7'h0C) mdl[p[3:0]] = wb[i] & ((p == 7'h00) ? 8'hBD : 8'hFF);
      if (!a[7]) wb[i] = (p < 7'h10) ? mdl[p[3:0]] : 8'hFF;
      wm[i] = (p == 7'h00) ? 8'hBF : 8'hFF;  // One-shot bit reads as unknown
      p = p + 7'h01;
    end
    for (i = 0; a[7] && i < 16; i += 4) begin
      ahb(1'b1, 8'h10 + 8'(i), {wb[i+3], wb[i+2], wb[i+1], wb[i]}, r);
    end
    ahb(1'b1, TCS_AHB_CMD, {15'h0, cp, 4'h0, 4'(n - 1), a}, r);
    for (i = 0; i < 4000; i++) begin
      rd(TCS_AHB_STATUS, 32'h0, 32'h0, r);
      if (r[TCS_STAT_BUSY_BIT] === 1'b0) break;
    end
    // A frame that never ends counts against the run
    chk("link idle", 32'h0, 32'(r[TCS_STAT_BUSY_BIT]));
    for (i = 0; !a[7] && i < n; i += 4) begin
      for (j = 0; j < 4; j++) begin
        e[8*j +: 8] = wb[i+j];
        m[8*j +: 8] = (i + j < n) ? wm[i+j] : 8'h00;
      end
      rd(8'h10 + 8'(i), e, m, r);
    end
  endtask

  // Watcher: each completed read takes the oldest note
  always @(posedge REF_CLK) begin
    if (rd_dp && HREADYOUT === 1'b1) begin
      nt = notes.pop_front();
      if (nt.m != 32'h0) chk("read data", nt.v & nt.m, HRDATA & nt.m);
      chk("response", 32'h0, 32'(HRESP));
    end
    if (HREADYOUT === 1'b1) rd_dp <= HSEL && HTRANS[1] && !HWRITE;
    if (CONVERT_START === 1'b1) n_conv++;
    if (FAULT_CLEAR === 1'b1) n_clr++;
  end

  // Watchdog at 50k cycles; the sequence needs about 18.5k
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    mdl = '{8'h00, 8'h03, 8'hFF, 8'h7F, 8'hC0, 8'h7F, 8'hFF, 8'h80,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    xfer(8'h00, 16, 1'b0);
    mdl[15] = rnd();
    FAULT_STATUS <= mdl[15];
    xfer(8'h81, 15, 1'b1);
    xfer(8'h00, 16, 1'b1);
    for (int k = 0; k < 12; k++) begin
      chk("control byte", 32'(mdl[k]), 32'(CTRL_REGS[8*k +: 8]));
    end
    xfer(8'h7E, 3, 1'b0);
    xfer(8'hFF, 2, 1'b1);
    repeat (16) @(posedge REF_CLK);
    chk("one-shot pulses", 32'h1, 32'(n_conv));
    chk("clear pulses", 32'h1, 32'(n_clr));
    chk("clear bit", 32'h0, 32'(CTRL_REGS[TCS_ALARM_FLAGS_CLEAR]));
    // New hot and cold results in the same cycle
    RESULT_VALID <= 1'b1;
    RESULT_DATA <= {rnd(), rnd(), rnd()};
    COLD_VALID <= 1'b1;
    COLD_DATA <= {rnd(), rnd()};
    @(posedge REF_CLK);
    RESULT_VALID <= 1'b0;
    COLD_VALID <= 1'b0;
    {mdl[12], mdl[13], mdl[14]} = RESULT_DATA;
    {mdl[10], mdl[11]} = COLD_DATA;
    repeat (8) @(posedge REF_CLK);
    rd(TCS_AHB_STATUS, 32'h2, 32'h2, junk);
    xfer(8'h0A, 5, 1'b0);
    repeat (16) @(posedge REF_CLK);
    rd(TCS_AHB_STATUS, 32'h0, 32'h2, junk);
    // Cold-only read also releases data ready while the sensor runs
    RESULT_VALID <= 1'b1;
    @(posedge REF_CLK);
    RESULT_VALID <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    rd(TCS_AHB_STATUS, 32'h2, 32'h2, junk);
    xfer(8'h0A, 2, 1'b1);
    repeat (16) @(posedge REF_CLK);
    rd(TCS_AHB_STATUS, 32'h0, 32'h2, junk);
    rd(8'h08, 32'h0, 32'hFFFFFFFF, junk);
    repeat (4) @(posedge REF_CLK);
    end_sim();
  end
endmodule // thermocouple_spi_register_port_tb
